// file: tb.sv
// Self-checking bench for the timer/counter control block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tcc_pkg::*;
    logic        clk, rst_n, wr, rd, go, busy;
    logic [7:0]  addr, wdata, rdata, got, r;
    logic [2:0]  pin;
    logic [1:0]  ext, ext_low;
    logic [4:0]  ack, irq;
    logic [3:0]  n;
    logic [4:0]  hold;
    logic [31:0] seed;
    int          errors, n_checks, i;
    logic [7:0]  exp_b [8];
    logic [7:0]  byte_addr [8] = '{8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hca, 8'hcb, 8'hcc, 8'hcd};

    tcc_top dut (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .TIMER0_COUNT_PIN_I(pin[0]), .TIMER1_COUNT_PIN_I(pin[1]),
        .TIMER2_COUNT_PIN_I(pin[2]), .FIRST_EXT_IRQ_PIN_I(ext[0]),
        .SECOND_EXT_IRQ_PIN_I(ext[1]), .ACK_T0_I(ack[0]), .ACK_T1_I(ack[1]),
        .ACK_T2_I(ack[2]), .ACK_EXT0_I(ack[3]), .ACK_EXT1_I(ack[4]), .IRQ_T0_O(irq[0]),
        .IRQ_T1_O(irq[1]), .IRQ_T2_O(irq[2]), .IRQ_EXT0_O(irq[3]), .IRQ_EXT1_O(irq[4]));
    tcc_pin_model u_pins (.clk_i(clk), .go_i(go), .n_i(n), .hold_i(hold),
        .ext_low_i(ext_low), .pin_o(pin), .ext_o(ext), .busy_o(busy));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Events counted on an 8-bit byte wrap naturally
    function automatic logic [7:0] exp_count(input logic [7:0] start, input logic [3:0] ev);
        return start + 8'(ev);
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want) begin
            errors++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask
    // Each access leaves one idle edge so a strobe is never set twice in a step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic pulse_ack(input int b);
        ack[b] <= 1'b1;
        @(posedge clk);
        ack[b] <= 1'b0;
        @(posedge clk);
    endtask
    task automatic end_sim();
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and scenarios
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Whole run needs well under two thousand cycles
    initial begin
        #500000;
        errors++;
        end_sim();
    end
    initial begin
        {rst_n, wr, rd, go} = '0;
        {addr, wdata, ack, ext_low, n, hold} = '0;
        seed = 32'h445b7c5a;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_reg(8'h88, got);
        check("control reset", got, 8'h00);
        rd_reg(8'h90, got);
        check("unmapped read", got, 8'h00);
        // Flag bits ignore writes, run and trigger bits keep them
        wr_reg(8'h88, 8'hff);
        rd_reg(8'h88, got);
        check("control bits", got, 8'h55);
        wr_reg(8'h88, 8'h00);
        foreach (byte_addr[j]) begin
            seed = xs(seed);
            exp_b[j] = seed[7:0];
            wr_reg(byte_addr[j], exp_b[j]);
        end
        foreach (byte_addr[j]) begin
            rd_reg(byte_addr[j], got);
            check("count byte", got, exp_b[j]);
        end
        // Timer function from a full count: wrap, then a step every twelve clocks
        wr_reg(8'h89, 8'h00);
        wr_reg(8'h8a, 8'hff);
        wr_reg(8'h8c, 8'hff);
        wr_reg(8'h88, 8'h10);
        for (i = 0; i < 14 && irq[0] !== 1'b1; i++) @(posedge clk);
        check("t0 wrap flag", {7'h00, irq[0]}, 8'h01);
        repeat (29) @(posedge clk);
        rd_reg(8'h8a, got);
        check("t0 ticks", got, 8'h02);
        wr_reg(8'h88, 8'h00);
        rd_reg(8'h88, got);
        check("t0 flag kept", got, 8'h20);
        pulse_ack(0);
        rd_reg(8'h88, got);
        check("t0 flag cleared", got, 8'h00);
        // Counter function on timers 1 and 2 with random pulse count and width
        seed = xs(seed);
        n    = 4'(2 + seed % 5);
        hold = 5'(12 + seed[11:8]);
        r    = {1'b0, seed[22:16]};
        wr_reg(8'h89, 8'h40);
        wr_reg(8'h8b, 8'hff);
        wr_reg(8'h8d, 8'hff);
        wr_reg(8'hcc, r);
        wr_reg(8'hcd, 8'h00);
        wr_reg(8'hc8, 8'h06);
        wr_reg(8'h88, 8'h40);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 2000 && busy; i++) @(posedge clk);
        repeat (40) @(posedge clk);
        wr_reg(8'h88, 8'h00);
        wr_reg(8'hc8, 8'h00);
        rd_reg(8'h8b, got);
        check("t1 events", got, exp_count(8'hff, n));
        rd_reg(8'h88, got);
        check("t1 wrap flag", got, 8'h80);
        rd_reg(8'hcc, got);
        check("t2 events", got, exp_count(r, n));
        pulse_ack(1);
        // Timer 2 wrap loads the capture value and sets its flag
        wr_reg(8'hcc, 8'hff);
        wr_reg(8'hcd, 8'hff);
        wr_reg(8'hc8, 8'h05);
        for (i = 0; i < 14 && irq[2] !== 1'b1; i++) @(posedge clk);
        wr_reg(8'hc8, 8'h00);
        rd_reg(8'hcc, got);
        check("t2 reload", got, exp_b[4]);
        rd_reg(8'hc8, got);
        check("t2 flag", got, 8'h80);
        pulse_ack(2);
        check("t2 flag clear", {7'h00, irq[2]}, 8'h00);
        // Level trigger on the first pin, edge trigger on the second
        ext_low <= 2'b01;
        repeat (3) @(posedge clk);
        ext_low <= 2'b00;
        rd_reg(8'h88, got);
        check("level flag", got, 8'h02);
        pulse_ack(3);
        rd_reg(8'h88, got);
        check("level flag clear", got, 8'h00);
        wr_reg(8'h88, 8'h04);
        ext_low <= 2'b10;
        repeat (3) @(posedge clk);
        rd_reg(8'h88, got);
        check("edge flag", got, 8'h0c);
        pulse_ack(4);
        rd_reg(8'h88, got);
        check("edge flag once", got, 8'h04);
        ext_low <= 2'b00;
        end_sim();
    end
endmodule

// file: tcc_edge_sample.sv
// Count pin sampler: falling edge seen between two samples gives one increment
module tcc_edge_sample
    import tcc_pkg::*;
(
    input  wire logic CLK_I,
    input  wire logic RST_N_I,
    input  wire logic tick_i,
    input  wire logic pin_i,
    output logic      inc_o
);
    logic smp_r;
    logic prev_r;

    // Sample once per tick; an edge needs two samples, so one count per 24 clocks
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            smp_r  <= 1'b0;
            prev_r <= 1'b0;
        end else if (tick_i) begin
            prev_r <= smp_r;
            smp_r  <= pin_i;
        end
    end

    // One pulse in the sample period right after the low sample
    assign inc_o = tick_i & prev_r & ~smp_r;
endmodule

// file: tcc_pin_model.sv
// Far-side model: count pulse source and external interrupt pin levels
module tcc_pin_model (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [3:0] n_i,
    input  wire logic [4:0] hold_i,
    input  wire logic [1:0] ext_low_i,
    output logic      [2:0] pin_o,
    output logic      [1:0] ext_o,
    output logic            busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int k;

    // Interrupt pins idle high so the level trigger stays quiet
    assign ext_o = ~ext_low_i;

    // Pulses on pins 1 and 2; each level held at least twelve clocks so no sample is missed
    initial begin
        pin_o  = 3'b111;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (go_i) begin
                busy_o <= 1'b1;
                for (k = 0; k < n_i; k++) begin
                    pin_o <= 3'b001;
                    repeat (hold_i) @(posedge clk_i);
                    pin_o <= 3'b111;
                    repeat (hold_i) @(posedge clk_i);
                end
                busy_o <= 1'b0;
            end
        end
    end
endmodule

// file: tcc_pkg.sv
// Package of constants for the timer/counter clock and control block
//
// What this block does
// - Three independent 16-bit timer/counters, each timing or counting events.
// - Timer function advances the count once per twelve oscillator periods.
// - Timer tick comes from the undivided oscillator, immune to divider and stalls.
// - Counter function advances only on a falling edge at its own count pin.
// - Count pin sampled every twelve periods; increment lands in the following period.
// - At most one counted event per twenty-four oscillator periods.
// - A divided core clock does not lengthen the sample period; it stays twelve oscillator periods.
// - Overflow flags bits 7 and 5: set on overflow, read-only, cleared on service.
// - Run bits 6 and 4 are read/write; one runs the timer, zero stops it.
// - Pin flags bits 3 and 1 set on pin event, cleared on service.
// - Trigger bits 2 and 0: one selects falling edge, zero low level.
// - Control register at 88h, resets to 00h.
// - Timer 0 count high byte at 8Ch, low byte at 8Ah.
// - Timer 1 count high byte at 8Dh, low byte at 8Bh.
// - Timer 2 count high byte at CDh, low byte at CCh.
// - Timer 2 capture/reload high byte at CBh, low byte at CAh.
// - Gate clear: run bit alone enables; gate set also needs pin high.
// - Function select zero times internal clock, one counts the count pin.
package tcc_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] TCC_ADDR_CONTROL = 8'h88;
    localparam logic [7:0] TCC_ADDR_MODE    = 8'h89;
    localparam logic [7:0] TCC_ADDR_T0_LOW  = 8'h8a;
    localparam logic [7:0] TCC_ADDR_T1_LOW  = 8'h8b;
    localparam logic [7:0] TCC_ADDR_T0_HIGH = 8'h8c;
    localparam logic [7:0] TCC_ADDR_T1_HIGH = 8'h8d;
    localparam logic [7:0] TCC_ADDR_T2_CTRL = 8'hc8;
    localparam logic [7:0] TCC_ADDR_CAP_LOW = 8'hca;
    localparam logic [7:0] TCC_ADDR_CAP_HI  = 8'hcb;
    localparam logic [7:0] TCC_ADDR_T2_LOW  = 8'hcc;
    localparam logic [7:0] TCC_ADDR_T2_HIGH = 8'hcd;

    // ****************************************************************
    // Control register fields and reset values
    // ****************************************************************
    localparam int TCC_BIT_OVF1  = 7;
    localparam int TCC_BIT_RUN1  = 6;
    localparam int TCC_BIT_OVF0  = 5;
    localparam int TCC_BIT_RUN0  = 4;
    localparam int TCC_BIT_IRQF1 = 3;
    localparam int TCC_BIT_TRIG1 = 2;
    localparam int TCC_BIT_IRQF0 = 1;
    localparam int TCC_BIT_TRIG0 = 0;
    // Mode select: per timer {gate, function}, timer 1 in the upper nibble
    localparam int TCC_BIT_GATE1 = 7;
    localparam int TCC_BIT_FUNC1 = 6;
    localparam int TCC_BIT_GATE0 = 3;
    localparam int TCC_BIT_FUNC0 = 2;
    // Timer 2 control: bit 2 run, bit 1 function, bit 7 overflow flag
    localparam int TCC_BIT_T2OVF  = 7;
    localparam int TCC_BIT_T2RUN  = 2;
    localparam int TCC_BIT_T2FUNC = 1;
    localparam int TCC_BIT_T2RELD = 0;
    localparam logic [7:0] TCC_CONTROL_RST = 8'h00;
    localparam logic [7:0] TCC_MODE_RST    = 8'h00;
    localparam logic [7:0] TCC_BYTE_RST    = 8'h00;

    // ****************************************************************
    // Timing: oscillator periods per sample / tick
    // ****************************************************************
    localparam int TCC_OSC_PER_TICK = 12;
    localparam logic [3:0] TCC_TICK_LAST = 4'(TCC_OSC_PER_TICK - 1);
endpackage

// file: tcc_prescale.sv
// Divide-by-twelve tick generator running from the undivided oscillator clock
module tcc_prescale
    import tcc_pkg::*;
(
    input  wire logic CLK_I,
    input  wire logic RST_N_I,
    output logic      tick_o
);
    logic [3:0] cnt_r;

    // Free running, so no divider, stall or bus cycle can stretch it
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            cnt_r <= 4'h0;
        end else if (cnt_r == TCC_TICK_LAST) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    assign tick_o = (cnt_r == TCC_TICK_LAST);
endmodule

// file: tcc_props.sv
// Port-level assertions for the timer/counter control block
module tcc_props
    import tcc_pkg::*;
(
    input wire logic       CLK_I,
    input wire logic       RST_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic       FIRST_EXT_IRQ_PIN_I,
    input wire logic       SECOND_EXT_IRQ_PIN_I,
    input wire logic       ACK_T0_I,
    input wire logic       ACK_T1_I,
    input wire logic       ACK_EXT0_I,
    input wire logic       IRQ_T0_O,
    input wire logic       IRQ_T1_O,
    input wire logic       IRQ_EXT0_O,
    input wire logic       IRQ_EXT1_O
);
    // ****************************************************************
    // Bus and flag relations
    // ****************************************************************
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    // Read data stands only in the cycle after a read
    rd_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data not idle");
    unmapped_rd_a: assert property (RD_I && !(ADDR_I inside {[8'h88:8'h8d], 8'hc8,
        [8'hca:8'hcd]}) |=> RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    // Timer 0 and 1 overflow flags hold until serviced; only timer 0's flag is checked to drop
    ovf0_hold_a: assert property (IRQ_T0_O && !ACK_T0_I |=> IRQ_T0_O)
        else $error("timer 0 flag lost");
    ovf1_hold_a: assert property (IRQ_T1_O && !ACK_T1_I |=> IRQ_T1_O)
        else $error("timer 1 flag lost");
    ovf0_clr_a: assert property (ACK_T0_I |=> !IRQ_T0_O)
        else $error("timer 0 flag not cleared");
    // A falling pin sets its flag in either trigger mode
    ext0_fell_a: assert property ($fell(FIRST_EXT_IRQ_PIN_I) |=> IRQ_EXT0_O)
        else $error("first pin flag not set");
    ext1_fell_a: assert property ($fell(SECOND_EXT_IRQ_PIN_I) |=> IRQ_EXT1_O)
        else $error("second pin flag not set");
    ext_cause_a: assert property ($rose(IRQ_EXT0_O) |-> !$past(FIRST_EXT_IRQ_PIN_I))
        else $error("first pin flag without low pin");
    ext0_hold_a: assert property (IRQ_EXT0_O && !ACK_EXT0_I |=> IRQ_EXT0_O)
        else $error("first pin flag lost");
    ext0_clr_a: assert property (ACK_EXT0_I && FIRST_EXT_IRQ_PIN_I |=> !IRQ_EXT0_O)
        else $error("first pin flag not cleared");

    cover property ($rose(IRQ_T0_O));
    cover property ($rose(IRQ_T1_O));
    cover property ($fell(SECOND_EXT_IRQ_PIN_I) ##1 IRQ_EXT1_O);
endmodule

bind tcc_top tcc_props u_props (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .FIRST_EXT_IRQ_PIN_I(FIRST_EXT_IRQ_PIN_I),
    .SECOND_EXT_IRQ_PIN_I(SECOND_EXT_IRQ_PIN_I), .ACK_T0_I(ACK_T0_I),
    .ACK_T1_I(ACK_T1_I), .ACK_EXT0_I(ACK_EXT0_I), .IRQ_T0_O(IRQ_T0_O),
    .IRQ_T1_O(IRQ_T1_O), .IRQ_EXT0_O(IRQ_EXT0_O), .IRQ_EXT1_O(IRQ_EXT1_O));

// file: tcc_top.sv
// Three 16-bit timer/counters with shared control register and pin flags
module tcc_top
    import tcc_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       RST_N_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    input  wire logic       TIMER0_COUNT_PIN_I,
    input  wire logic       TIMER1_COUNT_PIN_I,
    input  wire logic       TIMER2_COUNT_PIN_I,
    input  wire logic       FIRST_EXT_IRQ_PIN_I,
    input  wire logic       SECOND_EXT_IRQ_PIN_I,
    input  wire logic       ACK_T0_I,
    input  wire logic       ACK_T1_I,
    input  wire logic       ACK_T2_I,
    input  wire logic       ACK_EXT0_I,
    input  wire logic       ACK_EXT1_I,
    output logic            IRQ_T0_O,
    output logic            IRQ_T1_O,
    output logic            IRQ_T2_O,
    output logic            IRQ_EXT0_O,
    output logic            IRQ_EXT1_O
);
    // ****************************************************************
    // Behaviour notes
    // ****************************************************************
    // Timers 0 and 1 are plain 16-bit counters; the mode field of the
    // mode select register reads back but is not decoded.
    // Count bytes have no latch: a running count read as two bytes
    // can tear on a low-byte carry, so stop the timer first.
    // A byte write in an increment cycle wins and that step is lost.
    // Acknowledge inputs stand for interrupt service. A flag set in
    // its acknowledge cycle stays set, so no event is dropped.
    // Level trigger sets the pin flag each clock the pin is low;
    // service should wait for the pin to rise before it acks.
    // The tick runs free from reset, so the first step after a run
    // bit is set comes one to twelve clocks later.
    // Reads have no side effects; unmapped reads return zero and
    // unmapped writes are dropped.
    // Count pins need each level to hold twelve clocks or more, or
    // a short pulse can slip between two samples and be lost.

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0]  timer_control_r;
    logic [7:0]  timer_mode_select_r;
    logic [7:0]  timer2_control_r;
    logic [15:0] cnt0_r;
    logic [15:0] cnt1_r;
    logic [15:0] cnt2_r;
    logic [15:0] cap2_r;
    logic        ext0_prev_r;
    logic        ext1_prev_r;
    logic [7:0]  rdata_r;

    logic tick;
    logic ev0;
    logic ev1;
    logic ev2;
    logic en0;
    logic en1;
    logic en2;
    logic inc0;
    logic inc1;
    logic inc2;
    logic ovf0;
    logic ovf1;
    logic ovf2;
    logic ext0_evt;
    logic ext1_evt;
    logic wr_ctl;
    logic wr_mode;
    logic wr_t2ctl;
    logic wr_t0_hi;
    logic wr_t0_lo;
    logic wr_t1_hi;
    logic wr_t1_lo;
    logic wr_t2_hi;
    logic wr_t2_lo;
    logic wr_cap_hi;
    logic wr_cap_lo;

    // Enable term shared by timers 0 and 1
    function automatic logic run_ok(input logic run, input logic gate, input logic pin);
        run_ok = run & (~gate | pin);
    endfunction

    // Pick the tick or the sampled count-pin edge
    function automatic logic step(input logic en, input logic func, input logic tk,
                                  input logic ev);
        step = en & (func ? ev : tk);
    endfunction

    // Write strobe aimed at one register address
    function automatic logic wr_hit(input logic wr, input logic [7:0] a,
                                    input logic [7:0] target);
        wr_hit = wr && (a == target);
    endfunction

    // ****************************************************************
    // Clock sources
    // ****************************************************************
    tcc_prescale u_pre (
        .CLK_I   (CLK_I),
        .RST_N_I (RST_N_I),
        .tick_o  (tick)
    );

    tcc_edge_sample u_smp0 (
        .CLK_I   (CLK_I),
        .RST_N_I (RST_N_I),
        .tick_i  (tick),
        .pin_i   (TIMER0_COUNT_PIN_I),
        .inc_o   (ev0)
    );

    tcc_edge_sample u_smp1 (
        .CLK_I   (CLK_I),
        .RST_N_I (RST_N_I),
        .tick_i  (tick),
        .pin_i   (TIMER1_COUNT_PIN_I),
        .inc_o   (ev1)
    );

    tcc_edge_sample u_smp2 (
        .CLK_I   (CLK_I),
        .RST_N_I (RST_N_I),
        .tick_i  (tick),
        .pin_i   (TIMER2_COUNT_PIN_I),
        .inc_o   (ev2)
    );

    // ****************************************************************
    // Enables and increments
    // ****************************************************************
    // Gate lets the pin qualify the run bit, for pulse width measurement
    assign en0 = run_ok(timer_control_r[TCC_BIT_RUN0], timer_mode_select_r[TCC_BIT_GATE0],
                        FIRST_EXT_IRQ_PIN_I);
    assign en1 = run_ok(timer_control_r[TCC_BIT_RUN1], timer_mode_select_r[TCC_BIT_GATE1],
                        SECOND_EXT_IRQ_PIN_I);
    // Timer 2 has no gate: its run bit alone enables it
    assign en2 = timer2_control_r[TCC_BIT_T2RUN];

    assign inc0 = step(en0, timer_mode_select_r[TCC_BIT_FUNC0], tick, ev0);
    assign inc1 = step(en1, timer_mode_select_r[TCC_BIT_FUNC1], tick, ev1);
    assign inc2 = step(en2, timer2_control_r[TCC_BIT_T2FUNC], tick, ev2);

    // Wrap from all ones is the overflow event
    assign ovf0 = inc0 & (&cnt0_r);
    assign ovf1 = inc1 & (&cnt1_r);
    assign ovf2 = inc2 & (&cnt2_r);

    // Falling edge or low level, per trigger-type bit
    assign ext0_evt = timer_control_r[TCC_BIT_TRIG0] ?
                      (ext0_prev_r & ~FIRST_EXT_IRQ_PIN_I) : ~FIRST_EXT_IRQ_PIN_I;
    assign ext1_evt = timer_control_r[TCC_BIT_TRIG1] ?
                      (ext1_prev_r & ~SECOND_EXT_IRQ_PIN_I) : ~SECOND_EXT_IRQ_PIN_I;

    // Register write decode
    assign wr_ctl    = wr_hit(WR_I, ADDR_I, TCC_ADDR_CONTROL);
    assign wr_mode   = wr_hit(WR_I, ADDR_I, TCC_ADDR_MODE);
    assign wr_t2ctl  = wr_hit(WR_I, ADDR_I, TCC_ADDR_T2_CTRL);
    assign wr_t0_hi  = wr_hit(WR_I, ADDR_I, TCC_ADDR_T0_HIGH);
    assign wr_t0_lo  = wr_hit(WR_I, ADDR_I, TCC_ADDR_T0_LOW);
    assign wr_t1_hi  = wr_hit(WR_I, ADDR_I, TCC_ADDR_T1_HIGH);
    assign wr_t1_lo  = wr_hit(WR_I, ADDR_I, TCC_ADDR_T1_LOW);
    assign wr_t2_hi  = wr_hit(WR_I, ADDR_I, TCC_ADDR_T2_HIGH);
    assign wr_t2_lo  = wr_hit(WR_I, ADDR_I, TCC_ADDR_T2_LOW);
    assign wr_cap_hi = wr_hit(WR_I, ADDR_I, TCC_ADDR_CAP_HI);
    assign wr_cap_lo = wr_hit(WR_I, ADDR_I, TCC_ADDR_CAP_LOW);

    // ****************************************************************
    // Pin history for edge triggering
    // ****************************************************************
    // Resets high, so a pin held low through reset is taken as a falling edge
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ext0_prev_r <= 1'b1;
            ext1_prev_r <= 1'b1;
        end else begin
            ext0_prev_r <= FIRST_EXT_IRQ_PIN_I;
            ext1_prev_r <= SECOND_EXT_IRQ_PIN_I;
        end
    end

    // ****************************************************************
    // Shared control register
    // ****************************************************************
    // Flags are read-only: software writes touch only run and trigger bits.
    // A hardware set in the acknowledge cycle wins, so no event is lost.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            timer_control_r <= TCC_CONTROL_RST;
        end else begin
            if (wr_ctl) begin
                timer_control_r[TCC_BIT_RUN1]  <= WDATA_I[TCC_BIT_RUN1];
                timer_control_r[TCC_BIT_RUN0]  <= WDATA_I[TCC_BIT_RUN0];
                timer_control_r[TCC_BIT_TRIG1] <= WDATA_I[TCC_BIT_TRIG1];
                timer_control_r[TCC_BIT_TRIG0] <= WDATA_I[TCC_BIT_TRIG0];
            end
            if (ovf1) begin
                timer_control_r[TCC_BIT_OVF1] <= 1'b1;
            end else if (ACK_T1_I) begin
                timer_control_r[TCC_BIT_OVF1] <= 1'b0;
            end
            if (ovf0) begin
                timer_control_r[TCC_BIT_OVF0] <= 1'b1;
            end else if (ACK_T0_I) begin
                timer_control_r[TCC_BIT_OVF0] <= 1'b0;
            end
            if (ext1_evt) begin
                timer_control_r[TCC_BIT_IRQF1] <= 1'b1;
            end else if (ACK_EXT1_I) begin
                timer_control_r[TCC_BIT_IRQF1] <= 1'b0;
            end
            if (ext0_evt) begin
                timer_control_r[TCC_BIT_IRQF0] <= 1'b1;
            end else if (ACK_EXT0_I) begin
                timer_control_r[TCC_BIT_IRQF0] <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Mode select and timer 2 control
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            timer_mode_select_r <= TCC_MODE_RST;
        end else if (wr_mode) begin
            timer_mode_select_r <= WDATA_I;
        end
    end

    // Overflow flag here is hardware-set, cleared only on service
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            timer2_control_r <= TCC_BYTE_RST;
        end else begin
            if (wr_t2ctl) begin
                timer2_control_r[6:0] <= WDATA_I[6:0];
            end
            if (ovf2) begin
                timer2_control_r[TCC_BIT_T2OVF] <= 1'b1;
            end else if (ACK_T2_I) begin
                timer2_control_r[TCC_BIT_T2OVF] <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Count registers: software write takes priority over increment
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            cnt0_r <= 16'h0000;
        end else if (wr_t0_hi) begin
            cnt0_r[15:8] <= WDATA_I;
        end else if (wr_t0_lo) begin
            cnt0_r[7:0] <= WDATA_I;
        end else if (inc0) begin
            cnt0_r <= cnt0_r + 16'h0001;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            cnt1_r <= 16'h0000;
        end else if (wr_t1_hi) begin
            cnt1_r[15:8] <= WDATA_I;
        end else if (wr_t1_lo) begin
            cnt1_r[7:0] <= WDATA_I;
        end else if (inc1) begin
            cnt1_r <= cnt1_r + 16'h0001;
        end
    end

    // Timer 2 reloads from the capture value on overflow when enabled
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            cnt2_r <= 16'h0000;
        end else if (wr_t2_hi) begin
            cnt2_r[15:8] <= WDATA_I;
        end else if (wr_t2_lo) begin
            cnt2_r[7:0] <= WDATA_I;
        end else if (ovf2 && timer2_control_r[TCC_BIT_T2RELD]) begin
            cnt2_r <= cap2_r;
        end else if (inc2) begin
            cnt2_r <= cnt2_r + 16'h0001;
        end
    end

    // Capture value is software storage; no capture pin is modelled
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            cap2_r <= 16'h0000;
        end else if (wr_cap_hi) begin
            cap2_r[15:8] <= WDATA_I;
        end else if (wr_cap_lo) begin
            cap2_r[7:0] <= WDATA_I;
        end
    end

    // ****************************************************************
    // Read port: data one cycle after the strobe, zero when unmapped
    // ****************************************************************
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            rdata_r <= 8'h00;
        end else if (RD_I) begin
            case (ADDR_I)
                TCC_ADDR_CONTROL: rdata_r <= timer_control_r;
                TCC_ADDR_MODE:    rdata_r <= timer_mode_select_r;
                TCC_ADDR_T0_LOW:  rdata_r <= cnt0_r[7:0];
                TCC_ADDR_T0_HIGH: rdata_r <= cnt0_r[15:8];
                TCC_ADDR_T1_LOW:  rdata_r <= cnt1_r[7:0];
                TCC_ADDR_T1_HIGH: rdata_r <= cnt1_r[15:8];
                TCC_ADDR_T2_CTRL: rdata_r <= timer2_control_r;
                TCC_ADDR_CAP_LOW: rdata_r <= cap2_r[7:0];
                TCC_ADDR_CAP_HI:  rdata_r <= cap2_r[15:8];
                TCC_ADDR_T2_LOW:  rdata_r <= cnt2_r[7:0];
                TCC_ADDR_T2_HIGH: rdata_r <= cnt2_r[15:8];
                default:          rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign RDATA_O    = rdata_r;
    assign IRQ_T0_O   = timer_control_r[TCC_BIT_OVF0];
    assign IRQ_T1_O   = timer_control_r[TCC_BIT_OVF1];
    assign IRQ_T2_O   = timer2_control_r[TCC_BIT_T2OVF];
    assign IRQ_EXT0_O = timer_control_r[TCC_BIT_IRQF0];
    assign IRQ_EXT1_O = timer_control_r[TCC_BIT_IRQF1];
endmodule
